/* core/pscfg_bank.v */
// Pad slew-rate and drive-strength configuration register bank with an APB slave
//
// What this block does
// R01: Second slew register bits 3 and 2 have no storage and read zero.
// R02: Second slew register bits 1..0 hold the port E pins 3..0 edge level.
// R03: Slew codes 00..11 decode to levels 0..3 at the pads of the group.
// R04: Third slew register bits 7..4 are unimplemented and always read zero.
// R05: Third slew register bits 3..2 hold the port G pins 7..4 edge level.
// R06: Third slew register bits 1..0 hold the port G pins 3..0 edge level.
// R07: Drive strength is set per group of up to four pins, one bit each.
// R08: Strength bit 0 selects minimum current, 1 selects maximum current.
// R09: Low strength register bit 1 drives port A upper, bit 0 port A lower.
// R10: Low strength register bit 2 drives port B lower, bit 3 port B upper.
// R11: Low strength register bit 5 drives port C upper, bit 4 port C lower.
// R12: Low strength register bit 7 drives port D upper, bit 6 port D lower.
// R13: High strength register bit 5 drives port G upper, bit 4 port G lower.
// R14: High strength register bit 0 drives port E pins 3..0 on all variants.
// R15: Largest variant only: high register bits 3 and 2 drive port F upper, lower.
// R16: Smaller variants: high register bits 3..1 and 7..6 have no storage, read zero.
// R17: Reset clears every implemented slew and strength bit to zero.
// R18: Implemented bits are read/write over the bus and hold until rewritten or reset.
`include "pscfg_defines.vh"

module pscfg_bank #(
   parameter LARGE_VARIANT = 0
) (
   input wire mclk,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   output reg [3:0] port_e_edge_level,
   output reg [3:0] port_f_upper_edge_level,
   output reg [3:0] port_f_lower_edge_level,
   output reg [3:0] port_g_upper_edge_level,
   output reg [3:0] port_g_lower_edge_level,
   output wire port_a_lower_strength,
   output wire port_a_upper_strength,
   output wire port_b_lower_strength,
   output wire port_b_upper_strength,
   output wire port_c_lower_strength,
   output wire port_c_upper_strength,
   output wire port_d_lower_strength,
   output wire port_d_upper_strength,
   output wire port_e_strength,
   output wire port_f_lower_strength,
   output wire port_f_upper_strength,
   output wire port_g_lower_strength,
   output wire port_g_upper_strength
);

   // Storage masks fixed by the package variant
   localparam [7:0] MASK_SLEW_E = (LARGE_VARIANT != 0) ? `PSCFG_MASK_SLEW_E_LARGE : `PSCFG_MASK_SLEW_E_SMALL;
   localparam [7:0] MASK_DRV_HIGH = (LARGE_VARIANT != 0) ? `PSCFG_MASK_DRV_HIGH_LARGE : `PSCFG_MASK_DRV_HIGH_SMALL;

   reg [7:0] slew_ctrl_port_e_ff;
   reg [7:0] slew_ctrl_port_g_ff;
   reg [7:0] drive_strength_ctrl_low_ff;
   reg [7:0] drive_strength_ctrl_high_ff;
   reg [7:0] nxt_slew_ctrl_port_e;
   reg [7:0] nxt_slew_ctrl_port_g;
   reg [7:0] nxt_drive_strength_ctrl_low;
   reg [7:0] nxt_drive_strength_ctrl_high;
   reg [31:0] nxt_prdata;
   reg hit;
   wire [`PSCFG_ADDR_W-1:0] ofs;
   wire word_ok;
   wire wr_en;
   wire rd_en;

   // Zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   assign ofs = paddr[`PSCFG_ADDR_W-1:0];
   // Anything above the four words is unmapped; byte lanes 1..3 hold nothing
   assign word_ok = (paddr[31:`PSCFG_ADDR_W] == 28'h000_0000);
   assign wr_en = psel & penable & pwrite & pstrb[0];
   assign rd_en = psel & penable & ~pwrite;
   assign pslverr = psel & penable & ~hit;

   // Address decode, next register values and read mux
   always @* begin
      hit = 1'b0;
      nxt_slew_ctrl_port_e = slew_ctrl_port_e_ff;
      nxt_slew_ctrl_port_g = slew_ctrl_port_g_ff;
      nxt_drive_strength_ctrl_low = drive_strength_ctrl_low_ff;
      nxt_drive_strength_ctrl_high = drive_strength_ctrl_high_ff;
      nxt_prdata = `PSCFG_DATA_ZERO;
      if (word_ok) begin
         case (ofs)
            `PSCFG_OFS_SLEW_E: begin
               hit = 1'b1;
               // Unstored bits are masked on write so they always read zero
               if (wr_en) begin
                  nxt_slew_ctrl_port_e = pwdata[7:0] & MASK_SLEW_E; // R01 R02 R18
               end
               nxt_prdata = {24'h00_0000, slew_ctrl_port_e_ff}; // R01
            end
            `PSCFG_OFS_SLEW_G: begin
               hit = 1'b1;
               if (wr_en) begin
                  nxt_slew_ctrl_port_g = pwdata[7:0] & `PSCFG_MASK_SLEW_G; // R04 R05 R06 R18
               end
               nxt_prdata = {24'h00_0000, slew_ctrl_port_g_ff}; // R04
            end
            `PSCFG_OFS_DRV_LOW: begin
               hit = 1'b1;
               if (wr_en) begin
                  nxt_drive_strength_ctrl_low = pwdata[7:0] & `PSCFG_MASK_DRV_LOW; // R18
               end
               nxt_prdata = {24'h00_0000, drive_strength_ctrl_low_ff};
            end
            `PSCFG_OFS_DRV_HIGH: begin
               hit = 1'b1;
               if (wr_en) begin
                  nxt_drive_strength_ctrl_high = pwdata[7:0] & MASK_DRV_HIGH; // R15 R16 R18
               end
               nxt_prdata = {24'h00_0000, drive_strength_ctrl_high_ff}; // R16
            end
            default: begin
               hit = 1'b0;
            end
         endcase
      end
   end

   // Register storage, read data and decoded level selects
   // The one-hot selects are loaded from the next values so they track the fields with no extra lag
   always @(posedge mclk) begin
      if (!rstn) begin
         slew_ctrl_port_e_ff <= `PSCFG_RST_BYTE; // R17
         slew_ctrl_port_g_ff <= `PSCFG_RST_BYTE; // R17
         drive_strength_ctrl_low_ff <= `PSCFG_RST_BYTE; // R17
         drive_strength_ctrl_high_ff <= `PSCFG_RST_BYTE; // R17
         prdata <= `PSCFG_DATA_ZERO;
         port_e_edge_level <= `PSCFG_LVL_ONE; // R17
         port_f_upper_edge_level <= `PSCFG_LVL_ONE;
         port_f_lower_edge_level <= `PSCFG_LVL_ONE;
         port_g_upper_edge_level <= `PSCFG_LVL_ONE;
         port_g_lower_edge_level <= `PSCFG_LVL_ONE;
      end else begin
         slew_ctrl_port_e_ff <= nxt_slew_ctrl_port_e;
         slew_ctrl_port_g_ff <= nxt_slew_ctrl_port_g;
         drive_strength_ctrl_low_ff <= nxt_drive_strength_ctrl_low;
         drive_strength_ctrl_high_ff <= nxt_drive_strength_ctrl_high;
         // Read data is captured in the setup cycle so it is valid in the access cycle
         if (psel & ~penable & ~pwrite) begin
            prdata <= nxt_prdata;
         end else if (!rd_en) begin
            prdata <= `PSCFG_DATA_ZERO;
         end
         // Code n selects level n: bit n of the one-hot select
         port_e_edge_level <= `PSCFG_LVL_ONE << nxt_slew_ctrl_port_e[`PSCFG_SE_E_HI:`PSCFG_SE_E_LO]; // R02 R03
         port_f_upper_edge_level <= `PSCFG_LVL_ONE << nxt_slew_ctrl_port_e[`PSCFG_SE_FU_HI:`PSCFG_SE_FU_LO]; // R03
         port_f_lower_edge_level <= `PSCFG_LVL_ONE << nxt_slew_ctrl_port_e[`PSCFG_SE_FL_HI:`PSCFG_SE_FL_LO]; // R03
         port_g_upper_edge_level <= `PSCFG_LVL_ONE << nxt_slew_ctrl_port_g[`PSCFG_SG_U_HI:`PSCFG_SG_U_LO]; // R03 R05
         port_g_lower_edge_level <= `PSCFG_LVL_ONE << nxt_slew_ctrl_port_g[`PSCFG_SG_L_HI:`PSCFG_SG_L_LO]; // R03 R06
      end
   end

   // One stored bit per nibble group; 0 is minimum and 1 maximum current
   assign port_a_lower_strength = drive_strength_ctrl_low_ff[`PSCFG_DL_A_LO]; // R07 R08 R09
   assign port_a_upper_strength = drive_strength_ctrl_low_ff[`PSCFG_DL_A_UP]; // R09
   assign port_b_lower_strength = drive_strength_ctrl_low_ff[`PSCFG_DL_B_LO]; // R10
   assign port_b_upper_strength = drive_strength_ctrl_low_ff[`PSCFG_DL_B_UP]; // R10
   assign port_c_lower_strength = drive_strength_ctrl_low_ff[`PSCFG_DL_C_LO]; // R11
   assign port_c_upper_strength = drive_strength_ctrl_low_ff[`PSCFG_DL_C_UP]; // R11
   assign port_d_lower_strength = drive_strength_ctrl_low_ff[`PSCFG_DL_D_LO]; // R12
   assign port_d_upper_strength = drive_strength_ctrl_low_ff[`PSCFG_DL_D_UP]; // R12
   assign port_e_strength = drive_strength_ctrl_high_ff[`PSCFG_DH_E]; // R14
   // Port F bits have no storage on small variants, so these stay low there
   assign port_f_lower_strength = drive_strength_ctrl_high_ff[`PSCFG_DH_F_LO]; // R15
   assign port_f_upper_strength = drive_strength_ctrl_high_ff[`PSCFG_DH_F_UP]; // R15
   assign port_g_lower_strength = drive_strength_ctrl_high_ff[`PSCFG_DH_G_LO]; // R13
   assign port_g_upper_strength = drive_strength_ctrl_high_ff[`PSCFG_DH_G_UP]; // R13

endmodule // pscfg_bank

/* include/pscfg_defines.vh */
// Offsets, field positions, masks and reset values of the pad slew and drive configuration bank
`ifndef PSCFG_DEFINES_VH
`define PSCFG_DEFINES_VH

// Byte addresses of the four registers on the APB window
`define PSCFG_ADDR_W 4
`define PSCFG_OFS_SLEW_E 4'h0
`define PSCFG_OFS_SLEW_G 4'h4
`define PSCFG_OFS_DRV_LOW 4'h8
`define PSCFG_OFS_DRV_HIGH 4'hc

// Reset value of every register
`define PSCFG_RST_BYTE 8'h00
`define PSCFG_RST_FIELD 2'h0
`define PSCFG_RST_BIT 1'b0

// Slew field positions
`define PSCFG_SE_E_HI 1
`define PSCFG_SE_E_LO 0
`define PSCFG_SE_FU_HI 7
`define PSCFG_SE_FU_LO 6
`define PSCFG_SE_FL_HI 5
`define PSCFG_SE_FL_LO 4
`define PSCFG_SG_U_HI 3
`define PSCFG_SG_U_LO 2
`define PSCFG_SG_L_HI 1
`define PSCFG_SG_L_LO 0

// Drive strength bit positions, low register
`define PSCFG_DL_A_LO 0
`define PSCFG_DL_A_UP 1
`define PSCFG_DL_B_LO 2
`define PSCFG_DL_B_UP 3
`define PSCFG_DL_C_LO 4
`define PSCFG_DL_C_UP 5
`define PSCFG_DL_D_LO 6
`define PSCFG_DL_D_UP 7

// Drive strength bit positions, high register
`define PSCFG_DH_E 0
`define PSCFG_DH_F_LO 2
`define PSCFG_DH_F_UP 3
`define PSCFG_DH_G_LO 4
`define PSCFG_DH_G_UP 5

// Implemented bit masks per variant
`define PSCFG_MASK_SLEW_E_SMALL 8'h03
`define PSCFG_MASK_SLEW_E_LARGE 8'hf3
`define PSCFG_MASK_SLEW_G 8'h0f
`define PSCFG_MASK_DRV_LOW 8'hff
`define PSCFG_MASK_DRV_HIGH_SMALL 8'h31
`define PSCFG_MASK_DRV_HIGH_LARGE 8'h3d

// Level codes and one-hot level selects
`define PSCFG_LVL_W 4
`define PSCFG_LVL_ONE 4'h1
`define PSCFG_DATA_ZERO 32'h0000_0000
`define PSCFG_PAD_ZERO 24'h00_0000

`endif

/* tb/pad_slew_drive_config_tb_top.sv */
// Self-checking bench for the pad slew and drive configuration bank
module pad_slew_drive_config_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rstn, psel, penable, pwrite;
   logic [31:0] paddr, pwdata;
   logic [3:0] pstrb;
   wire pready, pslverr;
   wire [31:0] prdata;
   wire [3:0] lvl_e, lvl_gu, lvl_gl, lvl_fu, lvl_fl;
   // Strength pins in order A lo/up, B lo/up, C lo/up, D lo/up, E, F lo/up, G lo/up
   wire [12:0] str;
   int errors, n_compared;
   logic [32:0] q[$];
   logic [7:0] model[4];
   logic [7:0] mask[4] = '{8'h03, 8'h0f, 8'hff, 8'h31};
   pscfg_bank DUT (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
      .port_e_edge_level(lvl_e), .port_f_upper_edge_level(lvl_fu), .port_f_lower_edge_level(lvl_fl),
      .port_g_upper_edge_level(lvl_gu), .port_g_lower_edge_level(lvl_gl), .port_a_lower_strength(str[12]),
      .port_a_upper_strength(str[11]), .port_b_lower_strength(str[10]), .port_b_upper_strength(str[9]),
      .port_c_lower_strength(str[8]), .port_c_upper_strength(str[7]), .port_d_lower_strength(str[6]),
      .port_d_upper_strength(str[5]), .port_e_strength(str[4]), .port_f_lower_strength(str[3]),
      .port_f_upper_strength(str[2]), .port_g_lower_strength(str[1]), .port_g_upper_strength(str[0]));
   task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One APB transfer; the expected error flag and read byte are noted before setup
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      logic [32:0] e;
      e = {a[31:4] != 0 || a[1:0] != 0, 32'h0};
      if (!e[32] && !w) e[7:0] = model[a[3:2]];
      if (!e[32] && w && s[0]) model[a[3:2]] = d[7:0] & mask[a[3:2]];
      q.push_back(e);
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk);
      penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      psel <= 0;
      penable <= 0;
      // A lost answer is a mismatch and ends the run at the verdict
      if (i == 20) begin
         errors++;
         print_verdict;
      end
   endtask
   // Monitor compares every completed access with the oldest note
   always @(posedge mclk) if (psel && penable && pready === 1'b1) check({pslverr, pwrite ? 32'h0 : prdata},
      q.pop_front(), "bus");
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      int k;
      int r;
      logic [7:0] v;
      logic [7:0] h;
      rstn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      r = $urandom(79214);
      for (k = 0; k < 4; k++) model[k] = 8'h00;
      repeat (8) @(posedge mclk);
      rstn <= 1;
      for (k = 0; k < 4; k++) apb(0, k * 4, 0, 4'hf);
      // Every slew code on both slew registers
      for (k = 0; k < 4; k++) begin
         apb(1, 0, k, 4'hf);
         apb(1, 4, k * 5, 4'hf);
         #1;
         check(lvl_e, 33'h1 << k, "edge e");
         check({lvl_gu, lvl_gl}, {4'h1 << k, 4'h1 << k}, "edge g");
         check({lvl_fu, lvl_fl}, 8'h11, "edge f unstored");
      end
      // Random strength patterns; each nibble group follows its own bit
      repeat (8) begin
         v = $urandom;
         h = $urandom;
         apb(1, 8, v, 4'hf);
         apb(1, 12, h, 4'hf);
         #1;
         check(str[12:5], {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]}, "strength low");
         check(str[4:0], {h[0], 2'b00, h[4], h[5]}, "strength high");
      end
      // Random write then read back; unstored bits must come back zero
      repeat (40) begin
         r = $urandom_range(3);
         apb(1, r * 4, $urandom, 4'hf);
         apb(0, r * 4, 0, 4'hf);
      end
      apb(1, 8, 32'h5a, 4'he);
      apb(0, 8, 0, 4'hf);
      apb(1, 32'h10, 32'hff, 4'hf);
      apb(0, 32'h10, 0, 4'hf);
      apb(0, 32'h2, 0, 4'hf);
      // Reset in mid-run clears all stored bits
      @(posedge mclk);
      rstn <= 0;
      repeat (2) @(posedge mclk);
      rstn <= 1;
      for (k = 0; k < 4; k++) model[k] = 8'h00;
      for (k = 0; k < 4; k++) apb(0, k * 4, 0, 4'hf);
      print_verdict;
   end
endmodule // pad_slew_drive_config_tb_top

/* tb/pscfg_chk.sv */
// Port-level assertions for the pad slew and drive configuration bank
module pscfg_chk (
   input wire mclk,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire [3:0] port_e_edge_level,
   input wire [3:0] port_g_upper_edge_level,
   input wire [3:0] port_g_lower_edge_level,
   input wire port_a_lower_strength,
   input wire port_d_upper_strength,
   input wire port_e_strength,
   input wire port_g_upper_strength
);
   // Access and effective write qualifiers; a write without byte lane 0 changes nothing
   wire acc = psel && penable;
   wire wr = acc && pwrite && pstrb[0] && rstn;
   wire rd = acc && !pwrite;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   ready_always_a: assert property (pready) else $error("pready low");
   unmapped_err_a: assert property (acc && paddr[31:4] != 0 |-> pslverr) else $error("no error flag");
   slew_e_zero_a: assert property (rd && paddr == 0 |-> prdata[7:2] == 0) else $error("slew e hole");
   slew_g_zero_a: assert property (rd && paddr == 4 |-> prdata[31:4] == 0) else $error("slew g hole");
   drv_hi_zero_a: assert property (rd && paddr == 12 |-> prdata[7:6] == 0 && prdata[3:1] == 0)
      else $error("drive high hole");
   edge_e_code_a: assert property (wr && paddr == 0 |=> port_e_edge_level == 4'h1 << $past(pwdata[1:0]))
      else $error("port e level");
   edge_g_code_a: assert property (wr && paddr == 4 |=> port_g_upper_edge_level == 4'h1 << $past(pwdata[3:2])
      && port_g_lower_edge_level == 4'h1 << $past(pwdata[1:0])) else $error("port g level");
   drv_low_map_a: assert property (wr && paddr == 8 |=> {port_d_upper_strength, port_a_lower_strength}
      == {$past(pwdata[7]), $past(pwdata[0])}) else $error("drive low map");
   drv_high_map_a: assert property (wr && paddr == 12 |=> {port_g_upper_strength, port_e_strength}
      == {$past(pwdata[5]), $past(pwdata[0])}) else $error("drive high map");
   reset_clear_a: assert property (disable iff (1'b0) !rstn |=> port_e_edge_level == 4'h1 && !port_e_strength)
      else $error("reset state");
   strength_hold_a: assert property (!wr |=> $stable(port_a_lower_strength)) else $error("strength drift");
endmodule // pscfg_chk
bind pscfg_bank pscfg_chk u_chk (.*);
